// ==== arfwc_pkg.sv ====
// arfwc_pkg: register addresses, reset values, field positions and carrier types
// for the conversion result formatter and window comparator.
// assumes an 8-bit special-function register bus and a 12-bit converter core.
package arfwc_pkg;

    // =========================================================================
    // widths
    // =========================================================================
    localparam int RES_W  = 12;  // converter result width
    localparam int WORD_W = 16;  // justified data word width
    localparam int BYTE_W = 8;

    // =========================================================================
    // register addresses
    // =========================================================================
    localparam logic [7:0] ADDR_RESULT_LOW_BYTE        = 8'hbe;
    localparam logic [7:0] ADDR_RESULT_HIGH_BYTE       = 8'hbf;
    localparam logic [7:0] ADDR_UPPER_LIMIT_LOW_BYTE   = 8'hc4;
    localparam logic [7:0] ADDR_UPPER_LIMIT_HIGH_BYTE  = 8'hc5;
    localparam logic [7:0] ADDR_LOWER_LIMIT_LOW_BYTE   = 8'hc6;
    localparam logic [7:0] ADDR_LOWER_LIMIT_HIGH_BYTE  = 8'hc7;
    localparam logic [7:0] ADDR_CONVERTER_CONTROL      = 8'he8;

    // =========================================================================
    // reset values
    // =========================================================================
    localparam logic [7:0] RST_RESULT      = 8'h00;
    localparam logic [7:0] RST_UPPER_LIMIT = 8'hff;
    localparam logic [7:0] RST_LOWER_LIMIT = 8'h00;
    localparam logic       RST_FLAG        = 1'b0;
    localparam logic       RST_LJUST       = 1'b0;

    // =========================================================================
    // control register fields
    // =========================================================================
    localparam int CTRL_LJUST_BIT = 0;  // left_justify_select
    localparam int CTRL_FLAG_BIT  = 1;  // window_compare_flag

    // =========================================================================
    // carriers
    // =========================================================================
    typedef struct packed {
        logic       wr;     // one-cycle write strobe
        logic [7:0] addr;   // register address
        logic [7:0] wdata;  // write data
    } arfwc_sfr_req_t;

    typedef struct packed {
        logic             done;  // end-of-conversion pulse
        logic             diff;  // result is a differential reading
        logic [RES_W-1:0] data;  // raw result, two's complement when diff
    } arfwc_conv_t;

endpackage : arfwc_pkg

// ==== arfwc_window_cmp.sv ====
// arfwc_window_cmp: combinational window test of one justified data word.
// assumes the caller only samples the hit output on an end-of-conversion cycle.
`timescale 1ns/1ps
`default_nettype none
module arfwc_window_cmp #(
    parameter int W = 16
) (
    // data and limits
    input  wire logic [W-1:0] word,
    input  wire logic [W-1:0] upper_limit,
    input  wire logic [W-1:0] lower_limit,
    // comparison mode
    input  wire logic         signed_mode,
    // result
    output logic              hit
);

    // =========================================================================
    // order-preserving keys
    // =========================================================================
    logic [W-1:0] sign_flip;
    logic [W-1:0] key_word;
    logic [W-1:0] key_upper;
    logic [W-1:0] key_lower;

    // flipping the msb maps two's complement order onto unsigned order,
    // so one set of comparators serves both modes
    assign sign_flip = {signed_mode, {(W-1){1'b0}}};
    assign key_word  = word ^ sign_flip;
    assign key_upper = upper_limit ^ sign_flip;
    assign key_lower = lower_limit ^ sign_flip;

    // =========================================================================
    // window decision
    // =========================================================================
    logic below_lower;
    logic above_upper;

    assign below_lower = key_word < key_lower;
    assign above_upper = key_word > key_upper;

    // limits crossed give an inside window, otherwise an outside window
    always_comb begin
        if (key_lower > key_upper) begin
            hit = below_lower && above_upper;
        end else begin
            hit = below_lower || above_upper;
        end
    end

endmodule // arfwc_window_cmp
`default_nettype wire

// ==== arfwc_top.sv ====
// arfwc_top: result formatting, result/limit registers and window flag.
// assumes the register bus is the 8-bit special-function bus of the core:
// one-cycle write strobes and a combinational read of the addressed byte.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - left justified: low byte bits 7:4 hold result bits 3:0, bits 3:0 read zero
// - right justified: low byte holds result bits 7:0
// - right justified: high byte low nibble is top bits, upper nibble sign or zero
// - left justified: high byte then low upper nibble carry the whole 12 bits
// - single-ended results are unsigned in both justifications
// - differential results are two's complement in both justifications
// - every finished result is compared against both limit words autonomously
// - comparison happens at end of conversion; a hit sets the window flag
// - upper limit word is high byte then low byte, both reset to ones
// - lower limit word is high byte then low byte, both reset to zeros
// - lower above upper: hit only strictly between the two limits
// - lower not above upper: hit strictly below lower or strictly above upper
// - differential mode compares result and limits as signed values
// - control bit 0 selects left justification when one
module arfwc_top
    import arfwc_pkg::*;
(
    // clock and reset
    input  wire logic           sys_clk,
    input  wire logic           arst_n,
    // special-function register bus
    input  wire arfwc_sfr_req_t sfr_req,
    output logic [7:0]          sfr_rdata,
    output logic                sfr_hit,
    // converter core
    input  wire arfwc_conv_t    conv,
    // status towards the interrupt controller
    output logic                window_compare_flag,
    output logic                left_justify_select
);

    // =========================================================================
    // formatting
    // =========================================================================
    // builds the 16-bit word that software reads for a given raw result
    function automatic logic [WORD_W-1:0] fmt_word_f(
        input logic [RES_W-1:0] data,
        input logic             diff,
        input logic             ljust
    );
        logic [WORD_W-RES_W-1:0] ext;
        ext = {(WORD_W-RES_W){diff & data[RES_W-1]}};
        if (ljust) begin
            fmt_word_f = {data, {(WORD_W-RES_W){1'b0}}};
        end else begin
            fmt_word_f = {ext, data};
        end
    endfunction

    // =========================================================================
    // registers
    // =========================================================================
    logic [7:0] res_lo_r,   res_lo_nxt;
    logic [7:0] res_hi_r,   res_hi_nxt;
    logic [7:0] gt_lo_r,    gt_lo_nxt;
    logic [7:0] gt_hi_r,    gt_hi_nxt;
    logic [7:0] lt_lo_r,    lt_lo_nxt;
    logic [7:0] lt_hi_r,    lt_hi_nxt;
    logic       flag_r,     flag_nxt;
    logic       ljust_r,    ljust_nxt;

    logic [WORD_W-1:0] conv_word;
    logic [WORD_W-1:0] upper_word;
    logic [WORD_W-1:0] lower_word;
    logic              win_hit;
    logic              hw_set;

    // the word and the limits seen by the comparator
    assign conv_word  = fmt_word_f(conv.data, conv.diff, ljust_r);
    assign upper_word = {gt_hi_r, gt_lo_r};
    assign lower_word = {lt_hi_r, lt_lo_r};

    // =========================================================================
    // window comparator
    // =========================================================================
    arfwc_window_cmp #(
        .W (WORD_W)
    ) u_cmp (
        .word        (conv_word),
        .upper_limit (upper_word),
        .lower_limit (lower_word),
        .signed_mode (conv.diff),
        .hit         (win_hit)
    );

    // only an end-of-conversion qualifies, so idle data never raises the flag
    assign hw_set = conv.done & win_hit;

    // =========================================================================
    // next-state logic
    // =========================================================================
    // a write in the same cycle as an end of conversion loses to the result
    // for the result bytes, and the hardware set wins over a software clear
    always_comb begin
        res_lo_nxt = res_lo_r;
        res_hi_nxt = res_hi_r;
        gt_lo_nxt  = gt_lo_r;
        gt_hi_nxt  = gt_hi_r;
        lt_lo_nxt  = lt_lo_r;
        lt_hi_nxt  = lt_hi_r;
        flag_nxt   = flag_r;
        ljust_nxt  = ljust_r;
        if (sfr_req.wr) begin
            case (sfr_req.addr)
                ADDR_RESULT_LOW_BYTE: begin
                    res_lo_nxt = sfr_req.wdata;
                end
                ADDR_RESULT_HIGH_BYTE: begin
                    res_hi_nxt = sfr_req.wdata;
                end
                ADDR_UPPER_LIMIT_LOW_BYTE: begin
                    gt_lo_nxt = sfr_req.wdata;
                end
                ADDR_UPPER_LIMIT_HIGH_BYTE: begin
                    gt_hi_nxt = sfr_req.wdata;
                end
                ADDR_LOWER_LIMIT_LOW_BYTE: begin
                    lt_lo_nxt = sfr_req.wdata;
                end
                ADDR_LOWER_LIMIT_HIGH_BYTE: begin
                    lt_hi_nxt = sfr_req.wdata;
                end
                ADDR_CONVERTER_CONTROL: begin
                    flag_nxt  = sfr_req.wdata[CTRL_FLAG_BIT];
                    ljust_nxt = sfr_req.wdata[CTRL_LJUST_BIT];
                end
                default: begin
                    res_lo_nxt = res_lo_r;
                end
            endcase
        end
        // both bytes of one result are written in one edge
        if (conv.done) begin
            res_hi_nxt = conv_word[WORD_W-1:BYTE_W];
            res_lo_nxt = conv_word[BYTE_W-1:0];
        end
        if (hw_set) begin
            flag_nxt = 1'b1;
        end
    end

    // register stage only
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            res_lo_r <= RST_RESULT;
            res_hi_r <= RST_RESULT;
            gt_lo_r  <= RST_UPPER_LIMIT;
            gt_hi_r  <= RST_UPPER_LIMIT;
            lt_lo_r  <= RST_LOWER_LIMIT;
            lt_hi_r  <= RST_LOWER_LIMIT;
            flag_r   <= RST_FLAG;
            ljust_r  <= RST_LJUST;
        end else begin
            res_lo_r <= res_lo_nxt;
            res_hi_r <= res_hi_nxt;
            gt_lo_r  <= gt_lo_nxt;
            gt_hi_r  <= gt_hi_nxt;
            lt_lo_r  <= lt_lo_nxt;
            lt_hi_r  <= lt_hi_nxt;
            flag_r   <= flag_nxt;
            ljust_r  <= ljust_nxt;
        end
    end

    // =========================================================================
    // read path
    // =========================================================================
    // control bits other than the two kept here belong to other blocks and
    // read as zero from this one; the core ors the byte with its neighbours
    always_comb begin
        sfr_rdata = 8'h00;
        sfr_hit   = 1'b1;
        case (sfr_req.addr)
            ADDR_RESULT_LOW_BYTE:       sfr_rdata = res_lo_r;
            ADDR_RESULT_HIGH_BYTE:      sfr_rdata = res_hi_r;
            ADDR_UPPER_LIMIT_LOW_BYTE:  sfr_rdata = gt_lo_r;
            ADDR_UPPER_LIMIT_HIGH_BYTE: sfr_rdata = gt_hi_r;
            ADDR_LOWER_LIMIT_LOW_BYTE:  sfr_rdata = lt_lo_r;
            ADDR_LOWER_LIMIT_HIGH_BYTE: sfr_rdata = lt_hi_r;
            ADDR_CONVERTER_CONTROL: begin
                sfr_rdata[CTRL_FLAG_BIT]  = flag_r;
                sfr_rdata[CTRL_LJUST_BIT] = ljust_r;
            end
            default: begin
                sfr_hit = 1'b0;
            end
        endcase
    end

    assign window_compare_flag = flag_r;
    assign left_justify_select = ljust_r;

    // =========================================================================
    // checks
    // =========================================================================
    logic ctrl_wr;
    assign ctrl_wr = sfr_req.wr && (sfr_req.addr == ADDR_CONVERTER_CONTROL);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_left_low_zero: assert property (
        conv.done && ljust_r |=> (res_lo_r[3:0] == 4'h0)
            && (res_lo_r[7:4] == $past(conv.data[3:0])))
        else $error("left justified low byte wrong");

    a_right_low_byte: assert property (
        conv.done && !ljust_r |=> res_lo_r == $past(conv.data[7:0]))
        else $error("right justified low byte wrong");

    a_right_high_sign: assert property (
        conv.done && !ljust_r |=> res_hi_r[3:0] == $past(conv.data[11:8])
            && res_hi_r[7:4] == {4{$past(conv.diff) & $past(conv.data[11])}})
        else $error("right justified high byte wrong");

    a_left_high_byte: assert property (
        conv.done && ljust_r |=> res_hi_r == $past(conv.data[11:4]))
        else $error("left justified high byte wrong");

    a_inside_signed: assert property (
        conv.done && conv.diff
            && $signed(lower_word) > $signed(upper_word)
            && $signed(conv_word) < $signed(lower_word)
            && $signed(conv_word) > $signed(upper_word) |=> flag_r)
        else $error("signed inside window missed");

    a_outside_unsigned: assert property (
        conv.done && !conv.diff && lower_word <= upper_word
            && (conv_word < lower_word || conv_word > upper_word) |=> flag_r)
        else $error("unsigned outside window missed");

    a_set_beats_clear: assert property (
        hw_set && ctrl_wr && !sfr_req.wdata[CTRL_FLAG_BIT] |=> flag_r)
        else $error("hardware set lost to clear");

    a_flag_holds: assert property (
        flag_r && !ctrl_wr |=> flag_r)
        else $error("flag dropped without software");

    a_no_spurious: assert property (
        !flag_r && !ctrl_wr && !conv.done |=> !flag_r)
        else $error("flag set without conversion");

    a_ljust_write: assert property (
        ctrl_wr |=> ljust_r == $past(sfr_req.wdata[CTRL_LJUST_BIT]))
        else $error("justify select not taken");

    a_inside_unsigned: assert property (
        conv.done && !conv.diff && lower_word > upper_word
            && conv_word < lower_word && conv_word > upper_word |=> flag_r)
        else $error("unsigned inside window missed");

    a_outside_signed: assert property (
        conv.done && conv.diff
            && $signed(lower_word) <= $signed(upper_word)
            && ($signed(conv_word) < $signed(lower_word)
                || $signed(conv_word) > $signed(upper_word)) |=> flag_r)
        else $error("signed outside window missed");

    // a word equal to either limit lies outside an inside window, so it
    // must leave a clear flag clear
    a_limit_silent: assert property (
        conv.done && !conv.diff && !flag_r && !ctrl_wr && lower_word > upper_word
            && (conv_word == lower_word || conv_word == upper_word) |=> !flag_r)
        else $error("limit value raised the flag");

    a_diff_sign_ext: assert property (
        conv.done && !ljust_r && conv.diff && conv.data[RES_W-1]
            |=> res_hi_r[7:4] == 4'hf)
        else $error("negative result not sign extended");

    a_single_zero_ext: assert property (
        conv.done && !ljust_r && !conv.diff |=> res_hi_r[7:4] == 4'h0)
        else $error("single-ended high nibble not zero");

    // both bytes must come from the one result that just finished
    a_bytes_together: assert property (
        conv.done |=> {res_hi_r, res_lo_r} == $past(conv_word))
        else $error("result bytes from different results");

    // limit bytes follow the bus write directly; the compare only picks
    // them up at the next end of conversion
    a_upper_high_write: assert property (
        sfr_req.wr && sfr_req.addr == ADDR_UPPER_LIMIT_HIGH_BYTE
            |=> gt_hi_r == $past(sfr_req.wdata))
        else $error("upper limit high byte not written");

    a_upper_low_write: assert property (
        sfr_req.wr && sfr_req.addr == ADDR_UPPER_LIMIT_LOW_BYTE
            |=> gt_lo_r == $past(sfr_req.wdata))
        else $error("upper limit low byte not written");

    a_lower_high_write: assert property (
        sfr_req.wr && sfr_req.addr == ADDR_LOWER_LIMIT_HIGH_BYTE
            |=> lt_hi_r == $past(sfr_req.wdata))
        else $error("lower limit high byte not written");

    a_lower_low_write: assert property (
        sfr_req.wr && sfr_req.addr == ADDR_LOWER_LIMIT_LOW_BYTE
            |=> lt_lo_r == $past(sfr_req.wdata))
        else $error("lower limit low byte not written");

endmodule // arfwc_top
`default_nettype wire

// ==== arfwc_conv_model.sv ====
// arfwc_conv_model: behavioural converter core that feeds finished results.
// assumes the bench pulses start for one cycle and holds din until busy drops.
`timescale 1ns/1ps
`default_nettype none
module arfwc_conv_model
    import arfwc_pkg::*;
(
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    // request from the bench
    input  wire logic             start,
    input  wire logic [RES_W-1:0] din,
    input  wire logic             din_diff,
    input  wire logic [3:0]       dly,
    // towards the block
    output logic                  busy,
    output var arfwc_conv_t       conv
);
    logic [3:0] cnt_r;

    // ========================================
    // conversion timing
    // ========================================
    // data toggles outside the done cycle, so a late or early sample shows up
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy  <= 1'h0;
            cnt_r <= 4'h0;
            conv  <= '0;
        end else begin
            conv.done <= 1'h0;
            conv.data <= ~conv.data;
            if (start) begin
                busy      <= 1'h1;
                cnt_r     <= dly;
                conv.diff <= din_diff;
            end else if (busy) begin
                cnt_r <= cnt_r - 4'h1;
                if (cnt_r == 4'h0) begin
                    busy      <= 1'h0;
                    conv.done <= 1'h1;
                    conv.data <= din;
                end
            end
        end
    end
endmodule // arfwc_conv_model
`default_nettype wire

// ==== arfwc_tb_top.sv ====
// arfwc_tb_top: self-checking bench for the result formatter and window flag.
// assumes the converter model sits on conv and the bench drives the register bus.
`timescale 1ns/1ps
`default_nettype none
module arfwc_tb_top
    import arfwc_pkg::*;
;
    logic           sys_clk  = 1'h0;
    logic           arst_n   = 1'h0;
    arfwc_sfr_req_t sfr_req  = '0;
    logic           start    = 1'h0;
    logic [11:0]    din      = 12'h0;
    logic           din_diff = 1'h0;
    logic [3:0]     dly      = 4'h0;
    logic [7:0]     sfr_rdata;
    logic           sfr_hit;
    logic           flag;
    logic           ljs;
    logic           busy;
    arfwc_conv_t    conv;
    int             n_fail   = 0;
    int             checks   = 0;

    // ========================================
    // expected tables
    // ========================================
    // index 7 is unmapped on purpose
    localparam logic [7:0] RADDR [8] = '{8'hbe, 8'hbf, 8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'he8, 8'h10};
    localparam logic [7:0] RRST [8] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    // {ljust, diff, raw result, word}
    localparam logic [29:0] FMT [12] = '{
        {2'h0, 12'hfff, 16'h0fff}, {2'h2, 12'hfff, 16'hfff0}, {2'h0, 12'h800, 16'h0800},
        {2'h2, 12'h800, 16'h8000}, {2'h1, 12'h7ff, 16'h07ff}, {2'h3, 12'h7ff, 16'h7ff0},
        {2'h1, 12'hfff, 16'hffff}, {2'h3, 12'hfff, 16'hfff0}, {2'h1, 12'h800, 16'hf800},
        {2'h3, 12'h800, 16'h8000}, {2'h2, 12'ha5c, 16'ha5c0}, {2'h1, 12'h35c, 16'h035c}
    };
    // {ljust, diff, lower limit, upper limit, raw result, flag}
    localparam logic [46:0] WIN [18] = '{
        {2'h0, 16'h0200, 16'h0100, 12'h150, 1'h1}, {2'h0, 16'h0200, 16'h0100, 12'h200, 1'h0},
        {2'h0, 16'h0200, 16'h0100, 12'h100, 1'h0}, {2'h0, 16'h0200, 16'h0100, 12'h101, 1'h1},
        {2'h0, 16'h0100, 16'h0200, 12'h0ff, 1'h1}, {2'h0, 16'h0100, 16'h0200, 12'h100, 1'h0},
        {2'h0, 16'h0100, 16'h0200, 12'h201, 1'h1}, {2'h0, 16'h0100, 16'h0200, 12'h150, 1'h0},
        {2'h1, 16'h0100, 16'hffff, 12'h000, 1'h1}, {2'h1, 16'h0100, 16'hffff, 12'hfff, 1'h0},
        {2'h1, 16'h0100, 16'hffff, 12'h100, 1'h0}, {2'h1, 16'hffff, 16'h0100, 12'hffe, 1'h1},
        {2'h1, 16'hffff, 16'h0100, 12'h101, 1'h1}, {2'h1, 16'hffff, 16'h0100, 12'h000, 1'h0},
        {2'h2, 16'h2000, 16'h1000, 12'h101, 1'h1}, {2'h2, 16'h2000, 16'h1000, 12'h200, 1'h0},
        {2'h3, 16'h1000, 16'hfff0, 12'h000, 1'h1}, {2'h3, 16'h1000, 16'hfff0, 12'hfff, 1'h0}
    };

    // ========================================
    // design and converter model
    // ========================================
    arfwc_top i_arfwc_top (
        .sys_clk             (sys_clk),
        .arst_n              (arst_n),
        .sfr_req             (sfr_req),
        .sfr_rdata           (sfr_rdata),
        .sfr_hit             (sfr_hit),
        .conv                (conv),
        .window_compare_flag (flag),
        .left_justify_select (ljs)
    );
    arfwc_conv_model i_arfwc_conv_model (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .start    (start),
        .din      (din),
        .din_diff (din_diff),
        .dly      (dly),
        .busy     (busy),
        .conv     (conv)
    );

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    // ========================================
    // bus and check tasks
    // ========================================
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (n_fail == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // strobe stands one cycle, then a free edge before the next request
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_req <= '{wr: 1'h1, addr: a, wdata: d};
        @(posedge sys_clk);
        sfr_req.wr <= 1'h0;
    endtask
    // reads are combinational, so sample just after the address settles
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        sfr_req.addr <= a;
        #1;
        d = sfr_rdata;
    endtask
    task automatic lim(input logic [15:0] lo, input logic [15:0] up);
        wr(8'hc7, lo[15:8]);
        wr(8'hc6, lo[7:0]);
        wr(8'hc5, up[15:8]);
        wr(8'hc4, up[7:0]);
    endtask
    // bounded wait on busy; the block updates on the edge after done
    task automatic cnv(input logic [11:0] d, input logic df, input logic [3:0] t);
        @(posedge sys_clk);
        din      <= d;
        din_diff <= df;
        dly      <= t;
        start    <= 1'h1;
        @(posedge sys_clk);
        start <= 1'h0;
        repeat (20) begin
            @(posedge sys_clk);
            #1;
            if (!busy) break;
        end
        check({15'h0, busy}, 16'h0);
        @(posedge sys_clk);
        #1;
    endtask

    // ========================================
    // test sequence
    // ========================================
    initial begin
        logic [7:0]  b;
        logic [15:0] w;
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'h1;
        foreach (RADDR[i]) begin
            rd(RADDR[i], b);
            check({8'h0, b}, {8'h0, RRST[i]});
            check({15'h0, sfr_hit}, {15'h0, 1'(i < 7)});
        end
        wr(8'hc5, 8'h5a);
        rd(8'hc5, b);
        check({8'h0, b}, 16'h005a);
        wr(8'hbf, 8'h96);
        rd(8'hbf, b);
        check({8'h0, b}, 16'h0096);
        wr(8'he8, 8'hfd);
        rd(8'he8, b);
        check({8'h0, b}, 16'h0001);
        foreach (FMT[i]) begin
            wr(8'he8, {7'h0, FMT[i][29]});
            #1;
            check({15'h0, ljs}, {15'h0, FMT[i][29]});
            cnv(FMT[i][27:16], FMT[i][28], 4'(i % 5));
            rd(8'hbf, w[15:8]);
            rd(8'hbe, w[7:0]);
            check(w, FMT[i][15:0]);
        end
        foreach (WIN[i]) begin
            wr(8'he8, {7'h0, WIN[i][46]});
            lim(WIN[i][44:29], WIN[i][28:13]);
            cnv(WIN[i][12:1], WIN[i][45], 4'(i % 3));
            check({15'h0, flag}, {15'h0, WIN[i][0]});
        end
        // a later miss must leave a set flag alone
        wr(8'he8, 8'h00);
        lim(16'h0200, 16'h0100);
        cnv(12'h150, 1'h0, 4'h0);
        cnv(12'h300, 1'h0, 4'h2);
        rd(8'he8, b);
        check({8'h0, b}, 16'h0002);
        // a hit and a software clear on one edge: the hit must survive
        fork
            cnv(12'h150, 1'h0, 4'h0);
            begin
                repeat (2) @(posedge sys_clk);
                wr(8'he8, 8'h00);
            end
        join
        check({15'h0, flag}, 16'h1);
        wr(8'he8, 8'h00);
        #1;
        check({15'h0, flag}, 16'h0);
        // software may also raise the flag by writing bit 1
        wr(8'he8, 8'h02);
        #1;
        check({15'h0, flag}, 16'h1);
        print_verdict();
    end

    // watchdog far beyond the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        print_verdict();
    end
endmodule // arfwc_tb_top
`default_nettype wire
